// ===== hdl/sfs_map.svh
// Offsets, field positions, codes and timing counts of the serial flash front end.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// ==========================================================================
// Command codes
`define SFS_OP_ERASE_4K    8'h20
`define SFS_OP_ERASE_32K   8'h52
`define SFS_OP_ERASE_64K   8'hd8
`define SFS_OP_CHIP_A      8'h60
`define SFS_OP_CHIP_B      8'hc7
`define SFS_OP_WREN        8'h06
`define SFS_OP_WRDI        8'h04
`define SFS_OP_PROTECT     8'h36
`define SFS_OP_UNPROTECT   8'h39
`define SFS_OP_RD_STATUS   8'h05

// ==========================================================================
// Frame layout and address fields
`define SFS_OPCODE_BITS    6'd8
`define SFS_ADDR_FRAME     6'd32
`define SFS_ADDR_USED      21
`define SFS_SECT_LSB       16
`define SFS_SECT_MSB       20
`define SFS_SECTORS        32
`define SFS_ALIGN_4K       12
`define SFS_ALIGN_32K      15
`define SFS_ALIGN_64K      16
`define SFS_ARRAY_TOP      21'h1fffff

// ==========================================================================
// Status byte fields and timing
`define SFS_STAT_BUSY      0
`define SFS_STAT_WEL       1
`define SFS_ERASE_TIME_US  50
`define SFS_CLK_MHZ        100

`endif

// ===== hdl/sfs_pkg.sv
// Types shared by the serial flash front end modules.
// Assumes sfs_map.svh holds every numeric constant.
`include "sfs_map.svh"

package sfs_pkg;

	// ======================================================================
	// Types
	typedef struct packed {
		logic [7:0]  opcode;
		logic [23:0] addr;
	} sfs_cmd_type;

	typedef enum logic [1:0] {
		SFS_ER_4K,
		SFS_ER_32K,
		SFS_ER_64K,
		SFS_ER_CHIP
	} sfs_erase_type;

	typedef enum logic {
		SFS_ST_IDLE,
		SFS_ST_BUSY
	} sfs_state_type;

endpackage : sfs_pkg

// ===== hdl/sfs_stream_if.sv
// Valid and ready stream of captured command frames between core stages.
// Assumes both ends run on the core clock.
`timescale 1ns/1ns

interface sfs_stream_if;
	import sfs_pkg::*;

	logic        valid;
	logic        ready;
	sfs_cmd_type data;

	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);

endinterface : sfs_stream_if

// ===== hdl/sfs_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns

module sfs_buf2
	import sfs_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic srst_i,
	// Streams
	sfs_stream_if.dst in_s,
	sfs_stream_if.src out_s
);

	// ======================================================================
	// Storage
	sfs_cmd_type mem_r [2];
	logic        wr_ptr_r;
	logic        rd_ptr_r;
	logic [1:0]  count_r;
	wire         push;
	wire         pop;

	assign in_s.ready  = (count_r != 2'h2);
	assign out_s.valid = (count_r != 2'h0);
	assign out_s.data  = mem_r[rd_ptr_r];
	assign push        = in_s.valid & in_s.ready;
	assign pop         = out_s.valid & out_s.ready;

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_s.data;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			count_r  <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule : sfs_buf2

// ===== hdl/sfs_front_end.sv
// Serial flash front end: link shifter on the serial clock, command checks on the core clock.
// Assumes the host keeps chip select, pause and serial input steady around rising edges.
//
// Summary of operation
// R1 - While paused, serial clock and input are ignored and output floats.
// R2 - Pause starts only with chip select low and serial clock low; the code takes a pause at once at either clock level.
// R3 - Pausing never deselects or resets; shift state is kept.
// R4 - Pausing does not touch a running self-timed erase.
// R5 - Write-protect input low locks protected sectors against unprotect.
// R6 - Erase works on 4KB, 32KB, 64KB aligned blocks and whole chip.
// R7 - Codes D8h, 52h, 20h pick 64KB, 32KB, 4KB block erase.
// R8 - Thirty-two 64KB protection sectors counted upward, top ends at 1FFFFFh.
// R9 - Each sector has its own protect bit blocking its erases.
// R10 - Erase blocks are naturally aligned; top 4KB block is 1FF000h-1FFFFFh.
// R11 - Four lines: select, clock, input, output; host starts every command.
// R12 - Only serial modes 0 and 3 are supported.
// R13 - Either idle clock level is accepted between frames.
// R14 - Input sampled on rising clock edge, output changed on falling edge.
// R15 - Frame opens on select falling, closes on rising; deselected output floats.
// R16 - Bits shift most significant first, an 8-bit opcode leading.
// R17 - Three address bytes; the top three address bits are dropped.
// R18 - After a pause, shifting resumes at the very bit where it stopped.
`timescale 1ns/1ns
`include "sfs_map.svh"

module sfs_front_end
	import sfs_pkg::*;
#(
	parameter int ERASE_CYCLES = `SFS_ERASE_TIME_US * `SFS_CLK_MHZ
)(
	// Core clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	// Serial link
	input  wire logic        sck_i,
	input  wire logic        cs_n_i,
	input  wire logic        si_i,
	input  wire logic        hold_n_i,
	input  wire logic        wp_n_i,
	output logic             so_o,
	output logic             so_oe_o,
	// Erase request to the array
	output logic             erase_valid_o,
	output logic [20:0]      erase_base_o,
	output sfs_erase_type    erase_kind_o,
	input  wire logic        erase_ready_i,
	// Status
	output logic             busy_o,
	output logic             wel_o,
	output logic [31:0]      prot_o,
	output logic             reject_o,
	output logic             overrun_o
);

	// ======================================================================
	// Link domain: shifter on the serial clock
	logic [5:0]  bit_cnt_r;
	logic [31:0] shift_r;
	logic        done_r;
	logic        rd_stat_r;
	logic [31:0] word_r;
	logic        req_t_r;
	logic        so_r;
	logic        so_en_r;
	logic [1:0]  busy_l_r;
	logic [1:0]  wel_l_r;
	wire  [31:0] shift_nxt;
	wire  [7:0]  op_nxt;
	wire         no_addr_op;
	wire         frame_end;
	wire  [7:0]  stat_byte;

	assign shift_nxt  = {shift_r[30:0], si_i}; // [R16]
	assign op_nxt     = shift_nxt[7:0];
	assign no_addr_op = (op_nxt == `SFS_OP_WREN) | (op_nxt == `SFS_OP_WRDI) |
	                    (op_nxt == `SFS_OP_CHIP_A) | (op_nxt == `SFS_OP_CHIP_B) |
	                    (op_nxt == `SFS_OP_RD_STATUS);
	assign frame_end  = ~done_r & (((bit_cnt_r + 6'd1 == `SFS_OPCODE_BITS) & no_addr_op) |
	                    (bit_cnt_r + 6'd1 == `SFS_ADDR_FRAME)); // [R17]
	assign stat_byte  = {6'h00, wel_l_r[1], busy_l_r[1]};

	// Chip select high clears the frame, so a short frame starts no command.
	always_ff @(posedge sck_i or posedge cs_n_i) begin // [R15] [R13]
		if (cs_n_i) begin
			bit_cnt_r <= 6'h00;
			shift_r   <= 32'h0;
			done_r    <= 1'b0;
			rd_stat_r <= 1'b0;
		end else if (hold_n_i) begin // [R1] [R2] [R3] [R18] [R14]
			shift_r   <= shift_nxt;
			bit_cnt_r <= (bit_cnt_r == 6'h3f) ? bit_cnt_r : bit_cnt_r + 6'd1;
			if (frame_end) begin
				done_r    <= 1'b1;
				rd_stat_r <= (op_nxt == `SFS_OP_RD_STATUS);
			end
		end
	end

	// Toggle marks a finished frame; the word stays put until the next frame ends.
	always_ff @(posedge sck_i or posedge srst_i) begin
		if (srst_i) begin
			word_r  <= 32'h0;
			req_t_r <= 1'b0;
		end else if (~cs_n_i & hold_n_i & frame_end) begin // [R11]
			word_r  <= (bit_cnt_r + 6'd1 == `SFS_ADDR_FRAME) ? shift_nxt : {op_nxt, 24'h0};
			req_t_r <= ~req_t_r;
		end
	end

	// Status levels cross into the link domain through two flip-flops each.
	always_ff @(posedge sck_i) begin
		busy_l_r <= {busy_l_r[0], busy_o};
		wel_l_r  <= {wel_l_r[0], wel_o};
	end

	always_ff @(negedge sck_i or posedge cs_n_i) begin // [R14]
		if (cs_n_i) begin
			so_r    <= 1'b0;
			so_en_r <= 1'b0;
		end else if (hold_n_i && rd_stat_r) begin // [R1]
			so_r    <= stat_byte[3'd7 - bit_cnt_r[2:0]];
			so_en_r <= 1'b1;
		end
	end

	// The enable follows select and pause at once; a pause has no clock edge to wait on.
	assign so_o    = so_r;
	assign so_oe_o = so_en_r & ~cs_n_i & hold_n_i; // [R1] [R15] [R12]

	// ======================================================================
	// Core domain: crossing and buffering
	logic [2:0]  req_sync_r;
	logic [1:0]  wp_sync_r;
	logic        overrun_r;
	wire         req_evt;
	wire         wp_lock;

	sfs_stream_if cap_s ();
	sfs_stream_if cmd_s ();

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			req_sync_r <= 3'h0;
			wp_sync_r  <= 2'h3;
		end else begin
			req_sync_r <= {req_sync_r[1:0], req_t_r};
			wp_sync_r  <= {wp_sync_r[0], wp_n_i};
		end
	end

	assign req_evt     = req_sync_r[2] ^ req_sync_r[1];
	assign wp_lock     = ~wp_sync_r[1];
	assign cap_s.valid = req_evt;
	assign cap_s.data  = word_r;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			overrun_r <= 1'b0;
		end else if (req_evt & ~cap_s.ready) begin
			overrun_r <= 1'b1;
		end
	end
	assign overrun_o = overrun_r;

	sfs_buf2 u_buf (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.in_s      (cap_s),
		.out_s     (cmd_s)
	);

	// ======================================================================
	// Core domain: command checks, protection and erase timing
	sfs_state_type state_r;
	logic [31:0]   cnt_r;
	logic          wel_r;
	logic [31:0]   prot_r;
	logic          er_valid_r;
	logic [20:0]   er_base_r;
	sfs_erase_type er_kind_r;
	logic          reject_r;
	wire  [7:0]    op;
	wire  [20:0]   addr;
	wire  [4:0]    sect;
	wire           is_blk;
	wire           is_chip;
	wire           take;
	wire           sect_prot;
	wire           blk_ok;
	wire           chip_ok;
	wire           unprot_ok;
	sfs_erase_type kind;
	logic [20:0]   base;
	logic          busy_r;
	wire           busy_nxt;

	// A rest cycle after each refusal keeps back-to-back refusals as separate pulses.
	assign cmd_s.ready = (state_r == SFS_ST_IDLE) & ~er_valid_r & ~reject_r;
	assign take        = cmd_s.valid & cmd_s.ready;
	assign op          = cmd_s.data.opcode;
	assign addr        = cmd_s.data.addr[`SFS_ADDR_USED-1:0]; // [R17]
	assign sect        = addr[`SFS_SECT_MSB:`SFS_SECT_LSB]; // [R8]
	assign sect_prot   = prot_r[sect]; // [R9]
	assign is_blk      = (op == `SFS_OP_ERASE_4K) | (op == `SFS_OP_ERASE_32K) |
	                     (op == `SFS_OP_ERASE_64K);
	assign is_chip     = (op == `SFS_OP_CHIP_A) | (op == `SFS_OP_CHIP_B);
	assign blk_ok      = is_blk & wel_r & ~sect_prot; // [R9]
	assign chip_ok     = is_chip & wel_r & (prot_r == 32'h0);
	assign unprot_ok   = wel_r & ~(wp_lock & sect_prot); // [R5]
	// Busy leaves a flop, so the link-side synchroniser never sees a glitch between stages.
	assign busy_nxt    = (take & (blk_ok | chip_ok)) | er_valid_r |
	                     ((state_r == SFS_ST_BUSY) & (cnt_r != 32'h0)); // [R4]

	// Natural alignment clears the low bits of the given address.
	always_comb begin // [R6] [R7] [R10]
		kind = SFS_ER_CHIP;
		base = 21'h0;
		case (op)
			`SFS_OP_ERASE_4K: begin
				kind = SFS_ER_4K;
				base = {addr[20:`SFS_ALIGN_4K], 12'h000};
			end
			`SFS_OP_ERASE_32K: begin
				kind = SFS_ER_32K;
				base = {addr[20:`SFS_ALIGN_32K], 15'h0000};
			end
			`SFS_OP_ERASE_64K: begin
				kind = SFS_ER_64K;
				base = {addr[20:`SFS_ALIGN_64K], 16'h0000};
			end
			default: begin
				kind = SFS_ER_CHIP;
				base = 21'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wel_r  <= 1'b0;
			prot_r <= 32'hffffffff;
		end else if (take) begin
			if (op == `SFS_OP_WREN) begin
				wel_r <= 1'b1;
			end else if (op == `SFS_OP_WRDI) begin
				wel_r <= 1'b0;
			end else if (op == `SFS_OP_PROTECT && wel_r) begin
				prot_r[sect] <= 1'b1;
				wel_r        <= 1'b0;
			end else if (op == `SFS_OP_UNPROTECT && unprot_ok) begin // [R5]
				prot_r[sect] <= 1'b0;
				wel_r        <= 1'b0;
			end else if (blk_ok | chip_ok) begin
				wel_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			er_valid_r <= 1'b0;
			er_base_r  <= 21'h0;
			er_kind_r  <= SFS_ER_4K;
			reject_r   <= 1'b0;
		end else begin
			reject_r <= take & (((is_blk | is_chip) & ~(blk_ok | chip_ok)) |
			            ((op == `SFS_OP_UNPROTECT) & ~unprot_ok));
			if (take & (blk_ok | chip_ok)) begin
				er_valid_r <= 1'b1;
				er_base_r  <= base;
				er_kind_r  <= kind;
			end else if (erase_ready_i) begin
				er_valid_r <= 1'b0;
			end
		end
	end

	// The erase timer runs on the core clock only, so pauses on the link never reach it.
	always_ff @(posedge ref_clk_i) begin // [R4]
		if (srst_i) begin
			state_r <= SFS_ST_IDLE;
			cnt_r   <= 32'h0;
			busy_r  <= 1'b0;
		end else begin
			busy_r  <= busy_nxt;
			case (state_r)
				SFS_ST_IDLE: begin
					if (er_valid_r & erase_ready_i) begin
						state_r <= SFS_ST_BUSY;
						cnt_r   <= 32'(ERASE_CYCLES - 1);
					end
				end
				SFS_ST_BUSY: begin
					if (cnt_r == 32'h0) begin
						state_r <= SFS_ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 32'h1;
					end
				end
				default: begin
					state_r <= SFS_ST_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// Outputs
	assign erase_valid_o = er_valid_r;
	assign erase_base_o  = er_base_r;
	assign erase_kind_o  = er_kind_r;
	assign busy_o        = busy_r;
	assign wel_o         = wel_r;
	assign prot_o        = prot_r;
	assign reject_o      = reject_r;

endmodule : sfs_front_end

// ===== tb/sfs_front_end_assertions.sv
// Concurrent checks on the ports of the serial flash front end.
// Assumes a bind to sfs_front_end; every check runs on the core clock.
`timescale 1ns/1ns

module sfs_front_end_assertions
	import sfs_pkg::*;
(
	// Core clock and reset
	input wire logic          ref_clk_i,
	input wire logic          srst_i,
	// Link side
	input wire logic          cs_n_i,
	input wire logic          hold_n_i,
	input wire logic          wp_n_i,
	input wire logic          so_oe_o,
	// Array side and status
	input wire logic          erase_valid_o,
	input wire logic [20:0]   erase_base_o,
	input wire sfs_erase_type erase_kind_o,
	input wire logic          erase_ready_i,
	input wire logic          busy_o,
	input wire logic [31:0]   prot_o,
	input wire logic          reject_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);

	// ====
	// Checks
	deselect_float_a: assert property (cs_n_i |-> !so_oe_o)
		else $error("Output driven while deselected.");
	pause_float_a: assert property (!hold_n_i |-> !so_oe_o)
		else $error("Output driven during a pause.");
	req_hold_a: assert property (erase_valid_o && !erase_ready_i |=>
		erase_valid_o && $stable(erase_base_o) && $stable(erase_kind_o))
		else $error("Erase request changed while stalled.");
	req_drop_a: assert property (erase_valid_o && erase_ready_i |=> !erase_valid_o)
		else $error("Erase request stayed after acceptance.");
	align_4k_a: assert property (erase_valid_o && erase_kind_o == SFS_ER_4K
		|-> erase_base_o[11:0] == 12'h000) else $error("Small block base misaligned.");
	align_32k_a: assert property (erase_valid_o && erase_kind_o == SFS_ER_32K
		|-> erase_base_o[14:0] == 15'h0000) else $error("Middle block base misaligned.");
	align_64k_a: assert property (erase_valid_o && erase_kind_o == SFS_ER_64K
		|-> erase_base_o[15:0] == 16'h0000) else $error("Large block base misaligned.");
	sector_open_a: assert property (erase_valid_o |-> (erase_kind_o == SFS_ER_CHIP) ?
		prot_o == 32'h0 : !prot_o[erase_base_o[20:16]])
		else $error("Erase issued to a protected sector.");
	req_busy_a: assert property (erase_valid_o |-> busy_o)
		else $error("Busy low with a request pending.");
	reject_pulse_a: assert property (reject_o |=> !reject_o)
		else $error("Refusal pulse longer than one cycle.");
	wp_lock_a: assert property ((!wp_n_i) [*5] |=> (~prot_o & $past(prot_o)) == 32'h0)
		else $error("Sector unprotected while locked.");

	accept_c: cover property (erase_valid_o && erase_ready_i);
	stall_c: cover property (erase_valid_o && !erase_ready_i);
	reject_c: cover property (reject_o);
	pause_c: cover property (!hold_n_i && !cs_n_i);

endmodule : sfs_front_end_assertions

bind sfs_front_end sfs_front_end_assertions i_chk (.ref_clk_i, .srst_i, .cs_n_i, .hold_n_i,
	.wp_n_i, .so_oe_o, .erase_valid_o, .erase_base_o, .erase_kind_o, .erase_ready_i,
	.busy_o, .prot_o, .reject_o);

// ===== tb/sfs_spi_host.sv
// Serial host model that drives frames into the front end.
// Assumes the bench calls one frame at a time; the link clock stands still between frames.
`timescale 1ns/1ns

module sfs_spi_host (
	// Serial link
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o,
	output logic      hold_n_o,
	input  wire logic so_i
);
	logic       mode3 = 1'b0;
	logic [7:0] rx;

	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		hold_n_o = 1'b1;
	end

	// ====
	// Frame of n bits, most significant first, with a pause before bit pb.
	task automatic frame(input int n, input logic [31:0] d, input int pb);
		sck_o = mode3;
		#3 cs_n_o = 1'b0;
		#3;
		for (int i = n - 1; i >= 0; i--) begin
			sck_o = 1'b0;
			if (n - 1 - i == pb) begin
				hold_n_o = 1'b0;
				repeat (3) begin
					#3 sck_o = 1'b1;
					si_o = ~si_o;
					#3 sck_o = 1'b0;
				end
				hold_n_o = 1'b1;
			end
			si_o = d[i];
			#3 sck_o = 1'b1;
			rx = {rx[6:0], so_i};
			#3;
		end
		sck_o = mode3;
		#3 cs_n_o = 1'b1;
		si_o = ~si_o;
		#6;
	endtask : frame

endmodule : sfs_spi_host

// ===== tb/serial_flash_spi_front_end_tb_top.sv
// Self-checking bench for the serial flash front end.
// Assumes the host model for the link and drives the array side itself.
`timescale 1ns/1ns
`include "sfs_map.svh"

module serial_flash_spi_front_end_tb_top
	import sfs_pkg::*;
;
	logic          ref_clk_i = 1'b0;
	logic          srst_i = 1'b1;
	logic          wp_n_i = 1'b1;
	logic          erase_ready_i = 1'b1;
	wire logic     sck, cs_n, si, hold_n;
	logic          so_o, so_oe_o, erase_valid_o, busy_o, wel_o, reject_o, overrun_o;
	logic [20:0]   erase_base_o, got_base;
	sfs_erase_type erase_kind_o, got_kind;
	logic [31:0]   prot_o;
	int            fail_count = 0;
	int            checks = 0;
	int            rej_cnt = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	// A short erase time keeps the run small.
	sfs_front_end #(.ERASE_CYCLES(20)) i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.sck_i(sck), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i),
		.so_o(so_o), .so_oe_o(so_oe_o), .erase_valid_o(erase_valid_o),
		.erase_base_o(erase_base_o), .erase_kind_o(erase_kind_o),
		.erase_ready_i(erase_ready_i), .busy_o(busy_o), .wel_o(wel_o), .prot_o(prot_o),
		.reject_o(reject_o), .overrun_o(overrun_o));

	sfs_spi_host i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
		.so_i(so_oe_o ? so_o : 1'bz));

	always @(posedge ref_clk_i) begin
		if (reject_o === 1'b1)
			rej_cnt++;
		if (erase_valid_o === 1'b1 && erase_ready_i === 1'b1) begin
			got_base <= erase_base_o;
			got_kind <= erase_kind_o;
		end
	end

	// ====
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int pb);
		i_host.frame(32, {op, a}, pb);
		repeat (8) @(posedge ref_clk_i);
		#1;
	endtask : cmd

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_o !== 1'b0 && n < 200) begin
			@(posedge ref_clk_i);
			n++;
		end
		#1;
		check("busy", {31'h0, busy_o}, 32'h0);
	endtask : wait_idle

	task automatic do_reset();
		@(posedge ref_clk_i);
		#1 srst_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1 srst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		check("prot", prot_o, 32'hffffffff);
		check("status", {27'h0, erase_valid_o, busy_o, wel_o, reject_o, overrun_o}, 32'h0);
	endtask : do_reset

	// ====
	// Scenarios
	task automatic t_unprotect();
		cmd(`SFS_OP_WREN, 24'h0, 99);
		check("wel", {31'h0, wel_o}, 32'h1);
		cmd(`SFS_OP_UNPROTECT, 24'hfff123, 99);
		check("prot", prot_o, 32'h7fffffff);
	endtask : t_unprotect

	task automatic t_erase();
		logic [7:0]  ops [3] = '{`SFS_OP_ERASE_4K, `SFS_OP_ERASE_32K, `SFS_OP_ERASE_64K};
		logic [20:0] bases [3] = '{21'h1ff000, 21'h1f8000, 21'h1f0000};
		for (int k = 0; k < 3; k++) begin
			cmd(`SFS_OP_WREN, 24'h0, 99);
			cmd(ops[k], 24'hfff123, (k == 2) ? 13 : 99);
			wait_idle();
			check("base", {11'h0, got_base}, {11'h0, bases[k]});
			check("kind", {30'h0, got_kind}, k);
		end
	endtask : t_erase

	task automatic t_refuse();
		int r0;
		r0 = rej_cnt;
		cmd(`SFS_OP_ERASE_4K, 24'h1ff000, 99);
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_ERASE_4K, 24'h000010, 99);
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_CHIP_A, 24'h0, 99);
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_CHIP_B, 24'h0, 99);
		check("rejects", rej_cnt - r0, 32'h4);
	endtask : t_refuse

	task automatic t_status();
		@(posedge ref_clk_i);
		#1 erase_ready_i = 1'b0;
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_ERASE_64K, 24'h1f0000, 99);
		i_host.mode3 = 1'b1;
		i_host.frame(16, 32'h0500, 4);
		check("status byte", {24'h0, i_host.rx}, 32'h1);
		@(posedge ref_clk_i);
		#1 erase_ready_i = 1'b1;
		wait_idle();
		i_host.frame(16, 32'h0500, 99);
		check("status byte", {24'h0, i_host.rx}, 32'h0);
		i_host.mode3 = 1'b0;
	endtask : t_status

	task automatic t_wp_lock();
		@(posedge ref_clk_i);
		#1 wp_n_i = 1'b0;
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_UNPROTECT, 24'h1e0000, 99);
		check("prot", prot_o, 32'h7fffffff);
		@(posedge ref_clk_i);
		#1 wp_n_i = 1'b1;
		cmd(`SFS_OP_UNPROTECT, 24'h1e0000, 99);
		check("prot", prot_o, 32'h3fffffff);
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_PROTECT, 24'h1e0000, 99);
		check("prot", prot_o, 32'h7fffffff);
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_WRDI, 24'h0, 99);
		check("wel", {31'h0, wel_o}, 32'h0);
	endtask : t_wp_lock

	task automatic t_overrun();
		@(posedge ref_clk_i);
		#1 erase_ready_i = 1'b0;
		cmd(`SFS_OP_WREN, 24'h0, 99);
		cmd(`SFS_OP_ERASE_4K, 24'h1ff000, 99);
		repeat (4) cmd(`SFS_OP_WREN, 24'h0, 99);
		check("overrun", {31'h0, overrun_o}, 32'h1);
		@(posedge ref_clk_i);
		#1 erase_ready_i = 1'b1;
		wait_idle();
		do_reset();
	endtask : t_overrun

	// Watchdog; the run needs roughly a tenth of this span.
	initial begin
		#100000;
		fail_count++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1 srst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		do_reset();
		t_unprotect();
		t_erase();
		t_refuse();
		t_status();
		t_wp_lock();
		t_overrun();
		conclude();
	end

endmodule : serial_flash_spi_front_end_tb_top
